// file: verilog/ppo_pkg.sv
//----------------------------------------------------------------
// Shared constants for the pin override and sleep clamp block
//----------------------------------------------------------------
package ppo_pkg;

    // Default number of pins in one port
    localparam int PIN_COUNT_DEF = 8;

    // Pull-up code {direction, output value, global off} that turns pull-up on
    localparam logic [2:0] PULLUP_ON_CODE = 3'h2;

    // Reset values of the per-pin register bits (input, value zero: tri-state)
    localparam logic DIR_RESET_BIT = 1'h0;
    localparam logic VAL_RESET_BIT = 1'h0;
    localparam logic SYNC_RESET_BIT = 1'h0;

    // Direction bit encoding
    localparam logic DIR_OUTPUT = 1'h1;

endpackage : ppo_pkg

// file: verilog/ppo_sync_if.sv
`timescale 1ns/1ps
`default_nettype none

//----------------------------------------------------------------
// Carrier between pin logic and the input synchroniser
//----------------------------------------------------------------
interface ppo_sync_if #(
    parameter int WIDTH = ppo_pkg::PIN_COUNT_DEF
);
    logic [WIDTH-1:0] raw;      // Gated schmitt output, before sync
    logic [WIDTH-1:0] sampled;  // Synchronised pin value

    modport pin  (output raw, input sampled);
    modport sync (input raw, output sampled);
endinterface : ppo_sync_if

`default_nettype wire

// file: verilog/ppo_input_sync.sv
`timescale 1ns/1ps
`default_nettype none

//----------------------------------------------------------------
// Input synchroniser: clock-high latch then rising-edge register
//----------------------------------------------------------------
module ppo_input_sync #(
    parameter int WIDTH = ppo_pkg::PIN_COUNT_DEF
) (
    input  wire logic ref_clk_in,  // Port clock
    input  wire logic rst_n_in,    // Synchronous reset, active low
    ppo_sync_if.sync  sif          // Raw in, sampled out
);

    //----------------------------------------------------------------
    // Synchroniser stages
    //----------------------------------------------------------------
    logic [WIDTH-1:0] latch_r;     // First stage, read only by sampled_r
    logic [WIDTH-1:0] sampled_r;   // Second stage

    // Latch open while clock high; closes on falling edge.
    // Gives one half to one and a half periods of delay for a pad change.
    always_latch begin
        if (ref_clk_in) begin
            latch_r = sif.raw; // R18
        end
    end

    // Register takes the held latch value at the rising edge
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            sampled_r <= {WIDTH{ppo_pkg::SYNC_RESET_BIT}};
        end else begin
            sampled_r <= latch_r; // R18
        end
    end

    assign sif.sampled = sampled_r;

    //----------------------------------------------------------------
    // Checks
    //----------------------------------------------------------------
    // Inputs move just after the rising edge, so the value seen one edge
    // earlier must appear on the register one edge later.
    property p_sync_delay;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        $past(rst_n_in) |-> (sif.sampled == $past(sif.raw));
    endproperty
    a_sync_delay: assert property (p_sync_delay) // R18
        else $error("Synchronised value does not follow raw input by one edge");

endmodule : ppo_input_sync

`default_nettype wire

// file: verilog/ppo_port_pins.sv
`timescale 1ns/1ps
`default_nettype none

//----------------------------------------------------------------
// Port pin logic with peripheral overrides and sleep input clamp
//----------------------------------------------------------------
// Functional notes
// [R01] Deep sleep clamps digital input to ground
// [R02] No clamp on pins with external interrupt enabled
// [R03] Wake releases clamp, high pin flags interrupt
// [R04] Pull-ups off while reset is asserted
// [R05] No override: pull-up only for code 010
// [R06] Pull-up override enable selects override value
// [R07] Direction override selects output driver enable
// [R08] Drive value override selects driven pad level
// [R09] Toggle override inverts output-value bit
// [R10] Input gate override beats sleep state
// [R11] Raw schmitt output goes to peripherals unsynchronised
// [R12] Analog link is direct to pad
// [R13] Peripherals generate overrides; absent means inactive
// [R14] Clamp, pull-up off shared; strobes per port
// [R15] Direction one output; value drives or pulls
// [R16] Pin-input write of one toggles value
// [R17] Global pull-up off forces pull-ups off on pins without pull-up override; pull-up override value still applies
// [R18] Latch then register sampling of input
// [R19] Driver enable first; pull-up off when driving
module ppo_port_pins #(
    parameter int WIDTH = ppo_pkg::PIN_COUNT_DEF
) (
    input  wire logic             ref_clk_in,                // Port clock
    input  wire logic             rst_n_in,                  // Sync reset, active low
    // Register strobes, shared by all pins of the port
    input  wire logic             dir_wr_in,                 // Direction register write
    input  wire logic [WIDTH-1:0] dir_wdata_in,              // Direction write data
    input  wire logic             val_wr_in,                 // Output-value register write
    input  wire logic [WIDTH-1:0] val_wdata_in,              // Output-value write data
    input  wire logic             pin_wr_in,                 // Pin-input register write
    input  wire logic [WIDTH-1:0] pin_wdata_in,              // Ones toggle output value
    // Chip-wide controls
    input  wire logic             global_pullup_off_in,      // Disable pull-ups not under override
    input  wire logic             sleep_clamp_in,            // Deep sleep clamp request
    input  wire logic [WIDTH-1:0] ext_int_enable_in,         // External interrupt enabled
    input  wire logic [WIDTH-1:0] ext_int_async_edge_in,     // Async pin, edge/change sense
    // Per-pin peripheral overrides
    input  wire logic [WIDTH-1:0] pullup_override_enable,    // Pull-up override enable
    input  wire logic [WIDTH-1:0] pullup_override_value,     // Pull-up override value
    input  wire logic [WIDTH-1:0] direction_override_enable, // Direction override enable
    input  wire logic [WIDTH-1:0] direction_override_value,  // Direction override value
    input  wire logic [WIDTH-1:0] drive_value_override_enable, // Drive value override en
    input  wire logic [WIDTH-1:0] drive_value_override_value,  // Drive value override val
    input  wire logic [WIDTH-1:0] output_bit_toggle_override,  // Toggle output-value bit
    input  wire logic [WIDTH-1:0] input_gate_override_enable,  // Input gate override en
    input  wire logic [WIDTH-1:0] input_gate_override_value,   // Input gate override val
    // Pad
    input  wire logic [WIDTH-1:0] pad_in,                    // Level at the pad
    output logic      [WIDTH-1:0] pad_out,                   // Level driven to pad
    output logic      [WIDTH-1:0] pad_oe_out,                // Output driver enable
    output logic      [WIDTH-1:0] pad_pullup_out,            // Pull-up switch on
    // To peripherals and software
    output logic      [WIDTH-1:0] raw_schmitt_input_to_alt,  // Unsynchronised input
    output logic      [WIDTH-1:0] analog_pad_link,           // Direct pad level
    output logic      [WIDTH-1:0] ext_int_wake_set_out,      // Pulse: set interrupt flag
    output logic      [WIDTH-1:0] pin_direction_bit_out,     // Direction register
    output logic      [WIDTH-1:0] pin_output_value_bit_out,  // Output-value register
    output logic      [WIDTH-1:0] pin_sampled_input_bit_out  // Pin-input register
);

    // Elaboration check: the pin vectors are one to 32 bits wide
    if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
        $error("ppo_port_pins: WIDTH must be 1 to 32");
    end

    //----------------------------------------------------------------
    // Declarations
    //----------------------------------------------------------------
    logic [WIDTH-1:0] dir_r;        // Direction bits, one means output
    logic [WIDTH-1:0] val_r;        // Output-value bits
    logic [WIDTH-1:0] val_nxt;      // Next output-value bits
    logic [WIDTH-1:0] in_en;        // Digital input enable after clamp
    logic [WIDTH-1:0] in_en_prev_r; // Input enable one cycle ago
    logic [WIDTH-1:0] drv_en;       // Resolved output driver enable
    logic [WIDTH-1:0] pu_req;       // Pull-up request before gating

    ppo_sync_if #(.WIDTH(WIDTH)) sif ();

    //----------------------------------------------------------------
    // Register bits
    //----------------------------------------------------------------
    // Direction register; reset leaves every pin an input
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            dir_r <= {WIDTH{ppo_pkg::DIR_RESET_BIT}};
        end else if (dir_wr_in) begin
            dir_r <= dir_wdata_in; // R15
        end
    end

    // Write lands first, then any toggle from software or a peripheral
    // inverts it; both toggle sources together still invert only once.
    always_comb begin
        val_nxt = val_wr_in ? val_wdata_in : val_r;
        val_nxt = val_nxt ^ ((pin_wr_in ? pin_wdata_in : '0) // R16
                             | output_bit_toggle_override);  // R09
    end

    // Output-value register
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            val_r <= {WIDTH{ppo_pkg::VAL_RESET_BIT}};
        end else begin
            val_r <= val_nxt;
        end
    end

    //----------------------------------------------------------------
    // Per-pin pad logic
    //----------------------------------------------------------------
    // Overrides left unconnected by a peripheral must be tied low; the
    // pin then behaves as plain port logic. // R13
    for (genvar i = 0; i < WIDTH; i++) begin : g_pin
        // Driver enable resolved first from the direction path
        assign drv_en[i] = direction_override_enable[i] ? direction_override_value[i] // R07
                                                        : (dir_r[i] == ppo_pkg::DIR_OUTPUT);
        // Driven level then from the value path
        assign pad_out[i] = drive_value_override_enable[i] ? drive_value_override_value[i] // R08
                                                           : val_r[i]; // R15
        // Pull-up request: override value, else the 010 code
        assign pu_req[i] = pullup_override_enable[i] ? pullup_override_value[i] // R06
                         : ({dir_r[i], val_r[i], global_pullup_off_in} // R17 R14
                            == ppo_pkg::PULLUP_ON_CODE); // R05
        // Input enable: override first, else clamp in deep sleep
        // unless the external interrupt is armed on this pin
        assign in_en[i] = input_gate_override_enable[i] ? input_gate_override_value[i] // R10
                        : !(sleep_clamp_in && !ext_int_enable_in[i]); // R01 R02 R14
    end

    // Reset tri-states the pad even if a peripheral asks to drive
    assign pad_oe_out = rst_n_in ? drv_en : '0; // R19

    // Pull-up never fights the driver and is dropped during reset
    assign pad_pullup_out = (rst_n_in ? pu_req : '0) & ~pad_oe_out; // R04 R19

    // Clamp to ground ahead of the schmitt trigger
    assign sif.raw = pad_in & in_en; // R01
    assign raw_schmitt_input_to_alt = sif.raw; // R11

    // Analog path bypasses every gate; the pad wire itself carries any
    // analog drive from a peripheral.
    assign analog_pad_link = pad_in; // R12

    //----------------------------------------------------------------
    // Wake transition on asynchronous interrupt pins
    //----------------------------------------------------------------
    // Releasing the clamp lifts a high pin from ground; an edge-sensing
    // interrupt pin sees that rise, so its flag is set.
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            in_en_prev_r <= '1;
            ext_int_wake_set_out <= '0;
        end else begin
            in_en_prev_r <= in_en;
            ext_int_wake_set_out <= ~in_en_prev_r & in_en & pad_in // R03
                                    & ext_int_async_edge_in;
        end
    end

    //----------------------------------------------------------------
    // Synchroniser and register views
    //----------------------------------------------------------------
    ppo_input_sync #(.WIDTH(WIDTH)) u_sync (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .sif        (sif)
    );

    assign pin_direction_bit_out     = dir_r;
    assign pin_output_value_bit_out  = val_r;
    assign pin_sampled_input_bit_out = sif.sampled;

    //----------------------------------------------------------------
    // Checks
    //----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    property p_clamp;
        (sleep_clamp_in && !ext_int_enable_in[0] && !input_gate_override_enable[0])
            |-> !raw_schmitt_input_to_alt[0];
    endproperty
    a_clamp: assert property (p_clamp) // R01
        else $error("Input not clamped in deep sleep");

    property p_int_keeps_input;
        (ext_int_enable_in[0] && !input_gate_override_enable[0])
            |-> (raw_schmitt_input_to_alt[0] == pad_in[0]);
    endproperty
    a_int_keeps_input: assert property (p_int_keeps_input) // R02
        else $error("Clamp applied to interrupt-enabled pin");

    property p_wake_set;
        (sleep_clamp_in && !ext_int_enable_in[0] && !input_gate_override_enable[0])
            ##1 (!sleep_clamp_in && pad_in[0] && ext_int_async_edge_in[0]
                 && !input_gate_override_enable[0])
            |=> ext_int_wake_set_out[0];
    endproperty
    a_wake_set: assert property (p_wake_set) // R03
        else $error("Wake from clamp did not raise interrupt flag set");

    property p_reset_pullup;
        @(posedge ref_clk_in) disable iff (1'b0)
        !rst_n_in |-> (pad_pullup_out == '0) && (pad_oe_out == '0);
    endproperty
    a_reset_pullup: assert property (p_reset_pullup) // R04
        else $error("Pull-up or driver on during reset");

    property p_pullup_code;
        !pullup_override_enable[0] |->
            (pad_pullup_out[0] == (!dir_r[0] && val_r[0] && !global_pullup_off_in
                                   && !pad_oe_out[0]));
    endproperty
    a_pullup_code: assert property (p_pullup_code) // R05
        else $error("Pull-up does not match code 010");

    property p_pullup_ovr;
        (pullup_override_enable[0] && !pad_oe_out[0])
            |-> (pad_pullup_out[0] == pullup_override_value[0]);
    endproperty
    a_pullup_ovr: assert property (p_pullup_ovr) // R06
        else $error("Pull-up ignores override value");

    property p_dir_ovr;
        pad_oe_out[0] == (direction_override_enable[0] ? direction_override_value[0]
                                                       : dir_r[0]);
    endproperty
    a_dir_ovr: assert property (p_dir_ovr) // R07
        else $error("Driver enable wrong");

    property p_drive_val;
        (pad_oe_out[0] && !drive_value_override_enable[0]) |-> (pad_out[0] == val_r[0]);
    endproperty
    a_drive_val: assert property (p_drive_val) // R08
        else $error("Pad level does not follow output-value bit");

    property p_toggle;
        (output_bit_toggle_override[0] && !val_wr_in && !(pin_wr_in && pin_wdata_in[0]))
            |=> (val_r[0] != $past(val_r[0]));
    endproperty
    a_toggle: assert property (p_toggle) // R09
        else $error("Toggle override did not invert output value");

    property p_pin_toggle;
        (pin_wr_in && pin_wdata_in[0] && !val_wr_in && !output_bit_toggle_override[0])
            |=> (val_r[0] == !$past(val_r[0]));
    endproperty
    a_pin_toggle: assert property (p_pin_toggle) // R16
        else $error("Pin-input write of one did not toggle");

    property p_gate_ovr;
        input_gate_override_enable[0] |->
            (raw_schmitt_input_to_alt[0] == (pad_in[0] && input_gate_override_value[0]));
    endproperty
    a_gate_ovr: assert property (p_gate_ovr) // R10
        else $error("Input gate override not honoured");

    property p_no_pull_drive;
        pad_oe_out[0] |-> !pad_pullup_out[0];
    endproperty
    a_no_pull_drive: assert property (p_no_pull_drive) // R19
        else $error("Pull-up on while driving");

    c_wake:     cover property (ext_int_wake_set_out[0]);
    c_pullup:   cover property (pad_pullup_out[0] ##1 pad_oe_out[0]);
    c_clamped:  cover property (sleep_clamp_in && pad_in[0] && !raw_schmitt_input_to_alt[0]);
    c_override: cover property (direction_override_enable[0] && pad_oe_out[0]);

endmodule : ppo_port_pins

`default_nettype wire

// file: verification/ppo_alt_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Peripheral taking over pins
// ----------------------------------------
module ppo_alt_model #(
    parameter int W = 8
) (
    input  wire logic         ref_clk_in, // Port clock
    input  wire logic         rst_n_in,   // Sync reset
    input  wire logic [W-1:0] own_in,     // Pins taken over
    input  wire logic [W-1:0] dir_in,     // Wanted driver enable
    input  wire logic [W-1:0] drv_in,     // Wanted pad level
    input  wire logic [W-1:0] pu_in,      // Wanted pull-up
    input  wire logic [W-1:0] gate_in,    // Wanted input enable
    input  wire logic [W-1:0] tog_in,     // Toggle request
    output logic      [W-1:0] own_out,    // All override enables
    output logic      [W-1:0] dir_out,    // Direction override value
    output logic      [W-1:0] drv_out,    // Drive override value
    output logic      [W-1:0] pu_out,     // Pull-up override value
    output logic      [W-1:0] gate_out,   // Input gate override value
    output logic      [W-1:0] tog_out     // Toggle override
);
    // Overrides made inside the peripheral, registered like real logic
    // Unowned pins see every override inactive, never a stale value
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            own_out  <= '0;
            dir_out  <= '0;
            drv_out  <= '0;
            pu_out   <= '0;
            gate_out <= '0;
            tog_out  <= '0;
        end else begin
            own_out  <= own_in;
            dir_out  <= dir_in & own_in;
            drv_out  <= drv_in & own_in;
            pu_out   <= pu_in & own_in;
            gate_out <= gate_in & own_in;
            tog_out  <= tog_in & own_in;
        end
    end
endmodule : ppo_alt_model

`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Pin override bench
// ----------------------------------------
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end

module tb;
    logic       clk, rst_n;             // Clock, reset
    logic       dwr, vwr, pwr, gpo, slp; // Strobes, shared controls
    logic [7:0] dwd, vwd, pwd, ie, ae, pad; // Data, interrupt setup, pad
    logic [7:0] own, dirw, drvw, puw, gatew, togw; // Peripheral wishes
    logic [7:0] o_en, o_dir, o_drv, o_pu, o_gate, o_tog; // Overrides
    logic [7:0] p_out, p_oe, p_pu, raw, ana, wake, dir_q, val_q, smp;
    logic [2:0] kb;                     // Pull-up code under test
    int         fails, comparisons;

    ppo_alt_model #(.W(8)) peer (.ref_clk_in(clk), .rst_n_in(rst_n),
        .own_in(own), .dir_in(dirw), .drv_in(drvw), .pu_in(puw), .gate_in(gatew),
        .tog_in(togw), .own_out(o_en), .dir_out(o_dir), .drv_out(o_drv),
        .pu_out(o_pu), .gate_out(o_gate), .tog_out(o_tog));

    ppo_port_pins #(.WIDTH(8)) uut (.ref_clk_in(clk), .rst_n_in(rst_n),
        .dir_wr_in(dwr), .dir_wdata_in(dwd), .val_wr_in(vwr), .val_wdata_in(vwd),
        .pin_wr_in(pwr), .pin_wdata_in(pwd), .global_pullup_off_in(gpo),
        .sleep_clamp_in(slp), .ext_int_enable_in(ie), .ext_int_async_edge_in(ae),
        .pullup_override_enable(o_en), .pullup_override_value(o_pu),
        .direction_override_enable(o_en), .direction_override_value(o_dir),
        .drive_value_override_enable(o_en), .drive_value_override_value(o_drv),
        .output_bit_toggle_override(o_tog), .input_gate_override_enable(o_en),
        .input_gate_override_value(o_gate), .pad_in(pad), .pad_out(p_out),
        .pad_oe_out(p_oe), .pad_pullup_out(p_pu), .raw_schmitt_input_to_alt(raw),
        .analog_pad_link(ana), .ext_int_wake_set_out(wake),
        .pin_direction_bit_out(dir_q), .pin_output_value_bit_out(val_q),
        .pin_sampled_input_bit_out(smp));

    // 125 MHz clock
    always #4 clk = ~clk;

    // Wait n rising edges
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // One write cycle; s picks direction, value, pin-input strobes
    task automatic regs(input logic [2:0] s, input logic [7:0] dd, vd, pd);
        @(posedge clk);
        {dwr, vwr, pwr} <= s;
        dwd <= dd;
        vwd <= vd;
        pwd <= pd;
        @(posedge clk);
        {dwr, vwr, pwr} <= 3'h0;
    endtask : regs

    // Verdict and end of run
    task automatic end_of_test;
        if (fails == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0; rst_n = 1'b0; {dwr, vwr, pwr, gpo, slp} = 5'h00;
        {dwd, vwd, pwd, ie, ae} = 40'h0; pad = 8'h00;
        {own, dirw, drvw, puw, gatew, togw} = 48'h0;
        fails = 0; comparisons = 0;
        tick(6);
        rst_n <= 1'b1;
        @(negedge clk);
        `CHK("reset oe", 8'h00, p_oe)
        `CHK("reset val", 8'h00, val_q)
        // Every pull-up code; only input, one, not disabled pulls up
        for (int k = 0; k < 8; k++) begin
            kb = k[2:0];
            regs(3'h6, {8{kb[2]}}, {8{kb[1]}}, 8'h00);
            gpo <= kb[0];
            @(negedge clk);
            `CHK("pullup", (kb == 3'h2) ? 8'hFF : 8'h00, p_pu)
            `CHK("oe", {8{kb[2]}}, p_oe)
            `CHK("dir", {8{kb[2]}}, dir_q)
            `CHK("level", {8{kb[2] & kb[1]}}, p_out & p_oe)
        end
        // Reset in mid-run drops a live pull-up before the edge
        regs(3'h6, 8'h00, 8'hFF, 8'h00);
        gpo <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b0;
        @(negedge clk);
        `CHK("pullup in reset", 8'h00, p_pu)
        tick(2);
        rst_n <= 1'b1;
        @(negedge clk);
        `CHK("val after reset", 8'h00, val_q)
        // Pin-input write toggles, one idle cycle after a value write
        regs(3'h6, 8'h00, 8'h5A, 8'h00);
        regs(3'h1, 8'h00, 8'h00, 8'h0F);
        @(negedge clk);
        `CHK("pin toggle", 8'h55, val_q)
        // Override toggle meets a pin write on bit 4: one inversion only
        @(posedge clk);
        own <= 8'h31;
        togw <= 8'h31;
        @(posedge clk);
        togw <= 8'h00;
        pwr <= 1'b1;
        pwd <= 8'h10;
        @(posedge clk);
        pwr <= 1'b0;
        @(negedge clk);
        `CHK("ovr toggle", 8'h64, val_q)
        tick(2);
        @(negedge clk);
        `CHK("toggle once", 8'h64, val_q)
        regs(3'h3, 8'h00, 8'h00, 8'h81);
        @(negedge clk);
        `CHK("write then toggle", 8'h81, val_q)
        // Overrides on pins 0..3 against register settings
        regs(3'h6, 8'h3C, 8'hFF, 8'h00);
        own <= 8'h0F; dirw <= 8'h03; drvw <= 8'h01; puw <= 8'h05; gatew <= 8'h0F;
        gpo <= 1'b1;
        tick(1);
        @(negedge clk);
        `CHK("ovr oe", 8'h33, p_oe)
        `CHK("ovr level", 8'h31, p_out & p_oe)
        `CHK("ovr pullup", 8'h04, p_pu)
        @(posedge clk);
        own <= 8'h00;
        gpo <= 1'b0;
        // Pad edge: raw and analog at once, sampled a cycle later
        tick(2);
        pad <= 8'hA5;
        @(negedge clk);
        `CHK("raw", 8'hA5, raw)
        `CHK("analog", 8'hA5, ana)
        `CHK("not yet sampled", 8'h00, smp)
        @(negedge clk);
        `CHK("sampled", 8'hA5, smp)
        // Deep sleep: interrupt pin 0 and gate-on pin 1 escape, pin 3 gated off
        @(posedge clk);
        pad <= 8'hFF; slp <= 1'b1; ie <= 8'h01; own <= 8'h0A; gatew <= 8'h02;
        tick(1);
        @(negedge clk);
        `CHK("clamped raw", 8'h03, raw)
        @(posedge clk);
        slp <= 1'b0;
        @(negedge clk);
        `CHK("awake raw", 8'hF7, raw)
        `CHK("clamped sample", 8'h03, smp)
        // Wake with high async pins 0 to 2 whose interrupt is off
        @(posedge clk);
        own <= 8'h00; ie <= 8'h00; ae <= 8'h07; slp <= 1'b1;
        tick(2);
        slp <= 1'b0;
        tick(1);
        @(negedge clk);
        `CHK("wake flag", 8'h07, wake)
        @(negedge clk);
        `CHK("wake pulse end", 8'h00, wake)
        end_of_test();
    end
endmodule : tb

`default_nettype wire
